/* File: hdl/bstap_pkg.sv */
// bstap_pkg: constants and types for the boundary-scan test access block.
// assumes: a single system clock domain plus the test clock domain.
package bstap_pkg;

    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    localparam int          IR_LEN      = 4;
    localparam logic [3:0]  OP_EXTEST   = 4'h0;
    localparam logic [3:0]  OP_SAMPLE   = 4'h1;
    localparam logic [3:0]  OP_IDCODE   = 4'h2;
    localparam logic [3:0]  OP_INTEST   = 4'h3;
    localparam logic [3:0]  OP_CLAMP    = 4'h4;
    localparam logic [3:0]  OP_BYPASS   = 4'hf;
    localparam logic [3:0]  IR_CAPTURE  = 4'h1;
    localparam logic [3:0]  IR_RESET    = OP_IDCODE;

    // ------------------------------------------------------------------
    // identification register
    // ------------------------------------------------------------------
    localparam int          ID_LEN      = 32;
    localparam int          ID_VER_LSB  = 28;
    localparam int          ID_PART_LSB = 12;
    localparam int          ID_MFR_LSB  = 1;
    // identification fields; values are arbitrary
    localparam logic [3:0]  ID_VERSION  = 4'h1;
    localparam logic [15:0] ID_PART     = 16'h0a5c;
    localparam logic [10:0] ID_MFR      = 11'h07e;

    // ------------------------------------------------------------------
    // boundary register and fifo
    // ------------------------------------------------------------------
    localparam int          BSR_LEN     = 8;
    localparam int          FIFO_DEPTH  = 4;

    typedef enum logic [3:0] {
        ST_RESET  = 4'h0, ST_IDLE   = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SH_DR  = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR  = 4'h6, ST_EX2_DR = 4'h7,
        ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR  = 4'hb,
        ST_EX1_IR = 4'hc, ST_PA_IR  = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
    } bstap_state_e;

    // one boundary update word handed to the system side
    typedef struct packed {
        logic               ext_drive;
        logic               core_drive;
        logic [BSR_LEN-1:0] cells;
    } bstap_upd_s;

endpackage : bstap_pkg

/* File: hdl/bstap_top.sv */
// bstap_top: test access port controller, instruction decode, bypass,
// identification and boundary registers, plus a fifo and a handshake crossing
// that carry boundary update words into the system clock domain.
// assumes: tck is free of glitches; trst_n may be asserted asynchronously.
`timescale 1ns/1ps

// bstap_fifo: small synchronous fifo with valid/ready on both sides
module bstap_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // write side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // read side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // the pointer wrap bit only works for power-of-two depths
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least two");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("fifo width must be at least one");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;

    wire full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    wire empty = (wp_q == rp_q);
    wire push  = in_valid && !full;
    wire pop   = out_ready && !empty;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (reset) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule : bstap_fifo

// Operation
// - five test pins: mode select, clock, active-low reset, data in, data out.
// - decoder supports bypass, extest, intest, sample, clamp and idcode.
// - bypass selects a one-bit register as the only serial path.
// - extest drives output pins from cells and captures input pins.
// - intest applies cells to the core inputs and captures core outputs.
// - sample captures pin inputs while the part runs normally.
// - sample also preloads shifted values into the latched update stages.
// - clamp uses bypass as path while cells keep driving the pins.
// - controller rests in test-logic-reset during functional operation.
// - entering test-logic-reset loads idcode into the instruction register.
// - low test reset forces test-logic-reset asynchronously.
// - a 32-bit identification register with manufacturer, part and version.
// - idcode selects the identification register as serial path.
// - capture loads the fixed code, shift states move it out.
// - bit 31 nearest data in, bit 0 nearest data out, lsb first.
module bstap_top
    import bstap_pkg::*;
#(
    parameter int BSR_W = bstap_pkg::BSR_LEN
) (
    // system clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // test access port, five dedicated pins
    input  wire logic                tck,
    input  wire logic                tms,
    input  wire logic                trst_n,
    input  wire logic                tdi,
    output logic                     tdo,
    output logic                     tdo_oe,
    // boundary cells seen at the pins and core, in tck domain
    input  wire logic [BSR_W-1:0]    pin_in,
    input  wire logic [BSR_W-1:0]    core_out,
    // boundary update words in the system domain
    output logic [BSR_W-1:0]         bnd_cells,
    output logic                     bnd_ext_drive,
    output logic                     bnd_core_drive,
    output logic                     bnd_word_valid
);
    import bstap_pkg::*;

    // cell count is fixed by the package struct that carries the update word
    if (BSR_W != BSR_LEN) begin : g_bad_width
        $error("boundary width must match the package");
    end

    // ------------------------------------------------------------------
    // controller, tck domain
    // ------------------------------------------------------------------
    bstap_state_e st_q;
    bstap_state_e st_d;

    always_comb begin
        case (st_q)
            ST_RESET:  st_d = tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   st_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  st_d = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_d = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  st_d = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: st_d = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: st_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: st_d = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  st_d = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_d = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  st_d = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: st_d = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: st_d = tms ? ST_SEL_DR : ST_IDLE;
            default:   st_d = ST_RESET;
        endcase
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // instruction register and decode
    // ------------------------------------------------------------------
    logic [IR_LEN-1:0] ir_sh_q;
    logic [IR_LEN-1:0] ir_q;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_sh_q <= IR_CAPTURE;
            ir_q    <= IR_RESET;
        end else begin
            if (st_q == ST_CAP_IR) begin
                ir_sh_q <= IR_CAPTURE;
            end else if (st_q == ST_SH_IR) begin
                ir_sh_q <= {tdi, ir_sh_q[IR_LEN-1:1]};
            end
            if (st_q == ST_RESET) begin
                ir_q <= IR_RESET;
            end else if (st_q == ST_UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    // unknown opcodes fall back to bypass
    wire op_extest = (ir_q == OP_EXTEST);
    wire op_sample = (ir_q == OP_SAMPLE);
    wire op_idcode = (ir_q == OP_IDCODE);
    wire op_intest = (ir_q == OP_INTEST);
    wire sel_bsr   = op_extest || op_sample || op_intest;
    wire sel_byp   = !sel_bsr && !op_idcode;

    // ------------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------------
    logic              byp_q;
    logic [ID_LEN-1:0] id_q;
    logic [BSR_W-1:0]  bsr_q;
    logic [BSR_W-1:0]  bsr_upd_q;

    wire [ID_LEN-1:0] id_code = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
    wire [BSR_W-1:0]  bsr_cap = op_intest ? core_out : pin_in;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            byp_q     <= 1'b0;
            id_q      <= '0;
            bsr_q     <= '0;
            bsr_upd_q <= '0;
        end else begin
            if (st_q == ST_CAP_DR) begin
                byp_q <= 1'b0;
                if (op_idcode) begin
                    id_q <= id_code;
                end
                if (sel_bsr) begin
                    bsr_q <= bsr_cap;
                end
            end else if (st_q == ST_SH_DR) begin
                if (sel_byp) begin
                    byp_q <= tdi;
                end
                if (op_idcode) begin
                    id_q <= {tdi, id_q[ID_LEN-1:1]};
                end
                if (sel_bsr) begin
                    bsr_q <= {tdi, bsr_q[BSR_W-1:1]};
                end
            end
            if (st_q == ST_UPD_DR && sel_bsr) begin
                bsr_upd_q <= bsr_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // data out on falling edge
    // ------------------------------------------------------------------
    wire shifting = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
    wire dr_bit   = op_idcode ? id_q[0] : (sel_bsr ? bsr_q[0] : byp_q);
    wire tdo_d    = (st_q == ST_SH_IR) ? ir_sh_q[0] : dr_bit;

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= tdo_d;
            tdo_oe <= shifting;
        end
    end

    // ------------------------------------------------------------------
    // update word: hold on tck side, toggle handshake to clk
    // ------------------------------------------------------------------
    bstap_upd_s upd_word_q;
    logic       req_tgl_q;
    logic       ack_s1_q;
    logic       ack_s2_q;
    // written in the system domain, read here only through ack_s1_q
    logic       ack_tgl_q;

    // the word leaves on the edge that loads ir_q, so decode the value being loaded
    wire [IR_LEN-1:0] ir_new = (st_q == ST_RESET)  ? IR_RESET
                             : (st_q == ST_UPD_IR) ? ir_sh_q : ir_q;
    wire mode_ext  = (ir_new == OP_EXTEST) || (ir_new == OP_CLAMP);
    wire mode_core = (ir_new == OP_INTEST);
    wire upd_event = (st_q == ST_UPD_DR) || (st_q == ST_UPD_IR) || (st_q == ST_RESET);
    wire hs_idle   = (req_tgl_q == ack_s2_q);

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            upd_word_q <= '0;
            req_tgl_q  <= 1'b0;
            ack_s1_q   <= 1'b0;
            ack_s2_q   <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            // a later update while busy is merged into the next one
            if (hs_idle && upd_event) begin
                upd_word_q.ext_drive  <= mode_ext;
                upd_word_q.core_drive <= mode_core;
                upd_word_q.cells      <= (st_q == ST_UPD_DR && sel_bsr) ? bsr_q : bsr_upd_q;
                req_tgl_q             <= !req_tgl_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // system domain side
    // ------------------------------------------------------------------
    logic       req_s1_q;
    logic       req_s2_q;
    logic       req_s3_q;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    bstap_upd_s fifo_out;
    bstap_upd_s out_q;
    logic       out_valid_q;

    wire new_word = (req_s2_q != req_s3_q);
    wire take     = new_word && fifo_in_ready;

    always_ff @(posedge clk) begin
        if (reset) begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            req_s3_q  <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            if (take) begin
                req_s3_q  <= req_s2_q;
                ack_tgl_q <= req_s2_q;
            end
        end
    end

    bstap_fifo #(
        .WIDTH ($bits(bstap_upd_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (take),
        .in_ready  (fifo_in_ready),
        .in_data   (upd_word_q),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            out_q       <= '0;
            out_valid_q <= 1'b0;
        end else begin
            out_valid_q <= fifo_out_valid;
            if (fifo_out_valid) begin
                out_q <= fifo_out;
            end
        end
    end

    assign bnd_cells      = out_q.cells;
    assign bnd_ext_drive  = out_q.ext_drive;
    assign bnd_core_drive = out_q.core_drive;
    assign bnd_word_valid = out_valid_q;

endmodule : bstap_top

/* File: sim/bstap_top_sva.sv */
// bstap_top_sva: port-level checker for the test access block.
// assumes: bound to bstap_top; tck is far slower than clk.
`timescale 1ns/1ps
module bstap_chk
    import bstap_pkg::*;
#(
    parameter int BSR_W = BSR_LEN
) (
    // clocks and resets
    input wire logic             clk,
    input wire logic             reset,
    input wire logic             tck,
    input wire logic             trst_n,
    // serial output
    input wire logic             tdo,
    input wire logic             tdo_oe,
    // update words
    input wire logic [BSR_W-1:0] bnd_cells,
    input wire logic             bnd_ext_drive,
    input wire logic             bnd_core_drive,
    input wire logic             bnd_word_valid
);
    // ------------------------------------------------------------------
    // rising tck edges since test reset, saturating
    // ------------------------------------------------------------------
    logic [2:0] edge_q;
    logic [2:0] edge_d;
    assign edge_d = (edge_q == 3'h7) ? edge_q : edge_q + 3'h1;
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) edge_q <= 3'h0;
        else edge_q <= edge_d;
    end

    tdo_fall_a : assert property (
        @(posedge clk) disable iff (reset)
        $changed(tdo) && trst_n && $past(trst_n) |-> !tck)
        else $error("tdo moved while tck high");
    oe_fall_a : assert property (
        @(posedge clk) disable iff (reset)
        $changed(tdo_oe) && trst_n && $past(trst_n) |-> !tck)
        else $error("tdo_oe moved while tck high");
    trst_quiet_a : assert property (
        @(posedge clk) disable iff (reset) !trst_n |-> !tdo_oe && !tdo)
        else $error("serial output active in test reset");
    cells_hold_a : assert property (
        @(posedge clk) disable iff (reset) $changed(bnd_cells) |-> bnd_word_valid)
        else $error("cells changed without an update word");
    mode_hold_a : assert property (
        @(posedge clk) disable iff (reset)
        $changed({bnd_ext_drive, bnd_core_drive}) |-> bnd_word_valid)
        else $error("drive mode changed without an update word");
    mode_excl_a : assert property (
        @(posedge clk) disable iff (reset) !(bnd_ext_drive && bnd_core_drive))
        else $error("cells drive pins and core at once");
    late_shift_a : assert property (
        @(posedge tck) disable iff (!trst_n) tdo_oe |-> edge_q >= 3'h4)
        else $error("shift reached too soon after test reset");
    word_pulse_a : assert property (
        @(posedge clk) disable iff (reset) $rose(bnd_word_valid) |-> ##[1:3] !bnd_word_valid)
        else $error("update word pulse too long");
endmodule : bstap_chk

/* File: sim/bstap_host.sv */
// bstap_host: board scan controller model driving four test pins and sampling tdo.
// assumes: tck stands low between frames; tdi idles high as if pulled up.
`timescale 1ns/1ps
module bstap_host (
    // pins driven by the controller
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    // device answer
    input  wire logic tdo
);
    initial begin
        tck    = 1'b0;
        tms    = 1'b1;
        tdi    = 1'b1;
        trst_n = 1'b0;
    end

    // one tck cycle; tdo is taken just before the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #80 q = tdo;
        tck = 1'b1;
        #80 tck = 1'b0;
    endtask : step

    task automatic reset_tap();
        logic q;
        trst_n = 1'b0;
        #100 trst_n = 1'b1;
        #3 step(1'b0, 1'b1, q);
    endtask : reset_tap

    task automatic tlr();
        logic q;
        #3;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : tlr

    task automatic ir(input logic [3:0] op, output logic [3:0] cap);
        logic q;
        #3 step(1'b1, 1'b1, q);
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < 4; i++) begin
            step(i == 3, op[i], q);
            cap[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : ir

    task automatic dr(input logic [31:0] din, input int n, output logic [31:0] dout);
        logic q;
        dout = '0;
        #3 step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : dr
endmodule : bstap_host

/* File: sim/tb_bstap_top.sv */
// tb_bstap_top: self-checking bench for the test access block.
// assumes: bstap_host drives the test pins, bstap_chk is bound to the dut.
`timescale 1ns/1ps
module tb_bstap_top;
    import bstap_pkg::*;
    logic               clk, reset, tck, tms, trst_n, tdi, tdo, tdo_oe;
    logic [BSR_LEN-1:0] pin_in, core_out, bnd_cells;
    logic               bnd_ext_drive, bnd_core_drive, bnd_word_valid;
    logic [31:0]        got;
    logic [3:0]         cap;
    int                 error_cnt = 0;
    int                 samples_checked = 0;
    localparam logic [31:0] ID_EXP = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

    bstap_top #(.BSR_W(BSR_LEN)) u_dut (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
        .trst_n(trst_n), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
        .core_out(core_out), .bnd_cells(bnd_cells), .bnd_ext_drive(bnd_ext_drive),
        .bnd_core_drive(bnd_core_drive), .bnd_word_valid(bnd_word_valid));
    bstap_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic settle();
        repeat (10) @(negedge clk);
    endtask : settle

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_ident();
        fork
            u_host.dr(32'h0, 32, got);
            begin
                #2000;
                check("oe shift", tdo_oe, 1'b1);
            end
        join
        check("idcode", got, ID_EXP);
        check("oe idle", tdo_oe, 1'b0);
        $display("test ident done");
    endtask : t_ident

    task automatic t_bypass();
        logic [3:0] ops [2];
        ops = '{OP_BYPASS, 4'h7};
        for (int k = 0; k < 2; k++) begin
            u_host.ir(ops[k], cap);
            check("ir capture", cap, IR_CAPTURE);
            u_host.dr(32'hb5, 8, got);
            check("bypass path", got, 32'h6a);
        end
        $display("test bypass done");
    endtask : t_bypass

    task automatic t_sample_extest();
        pin_in = 8'h5a;
        u_host.ir(OP_SAMPLE, cap);
        u_host.dr(32'hc3, 8, got);
        settle();
        check("sample capture", got, 32'h5a);
        check("sample drive", {bnd_ext_drive, bnd_core_drive}, 2'b00);
        check("preload cells", bnd_cells, 8'hc3);
        pin_in = 8'h3c;
        u_host.ir(OP_EXTEST, cap);
        settle();
        check("extest preload", bnd_cells, 8'hc3);
        check("extest drive", {bnd_ext_drive, bnd_core_drive}, 2'b10);
        u_host.dr(32'h96, 8, got);
        settle();
        check("extest capture", got, 32'h3c);
        check("extest cells", bnd_cells, 8'h96);
        $display("test sample extest done");
    endtask : t_sample_extest

    task automatic t_intest_clamp();
        core_out = 8'ha7;
        u_host.ir(OP_INTEST, cap);
        u_host.dr(32'h11, 8, got);
        settle();
        check("intest capture", got, 32'ha7);
        check("intest drive", {bnd_ext_drive, bnd_core_drive}, 2'b01);
        check("intest cells", bnd_cells, 8'h11);
        u_host.ir(OP_CLAMP, cap);
        u_host.dr(32'hb5, 8, got);
        settle();
        check("clamp path", got, 32'h6a);
        check("clamp drive", {bnd_ext_drive, bnd_core_drive}, 2'b10);
        check("clamp cells", bnd_cells, 8'h11);
        $display("test intest clamp done");
    endtask : t_intest_clamp

    task automatic t_test_reset();
        u_host.tlr();
        settle();
        check("reset drive", {bnd_ext_drive, bnd_core_drive}, 2'b00);
        u_host.dr(32'h0, 32, got);
        check("reset idcode", got, ID_EXP);
        u_host.ir(OP_BYPASS, cap);
        u_host.reset_tap();
        check("trst oe", tdo_oe, 1'b0);
        u_host.dr(32'h0, 32, got);
        check("trst idcode", got, ID_EXP);
        $display("test reset done");
    endtask : t_test_reset

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        reset    = 1'b1;
        pin_in   = '0;
        core_out = '0;
        repeat (4) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        u_host.reset_tap();
        t_ident();
        t_bypass();
        t_sample_extest();
        t_intest_clamp();
        t_test_reset();
        close_out();
    end

    initial begin
        #300000;
        error_cnt++;
        $display("watchdog expired");
        close_out();
    end
endmodule : tb_bstap_top

bind bstap_top bstap_chk #(.BSR_W(BSR_W)) u_chk (.clk, .reset, .tck, .trst_n, .tdo, .tdo_oe,
    .bnd_cells, .bnd_ext_drive, .bnd_core_drive, .bnd_word_valid);
